// File: verilog/sfrs_consts.svh
`ifndef SFRS_CONSTS_SVH
`define SFRS_CONSTS_SVH

// Local clock
`define SFRS_CLK_MHZ 200
`define SFRS_CLK_NS 5

// Time to cycles: least times round up, longest times round down
`define SFRS_CYC_UP(ns) (((ns) + `SFRS_CLK_NS - 1) / `SFRS_CLK_NS)
`define SFRS_CYC_DN(ns) ((ns) / `SFRS_CLK_NS)

// Reset sequence and deselect gap times in ns
`define SFRS_POWER_UP_INTERVAL_NS 300000
`define SFRS_RESET_RECOVERY_HOLD_NS 35000
`define SFRS_RESET_PULSE_WIDTH_NS 200
`define SFRS_RELEASE_TO_SELECT_DELAY_NS 50
`define SFRS_RESET_REARM_SETUP_NS 50
`define SFRS_DESELECT_GAP_READ_NS 10
`define SFRS_DESELECT_GAP_PROG_NS 50

// Cycle counts
`define SFRS_PU_CYC `SFRS_CYC_DN(`SFRS_POWER_UP_INTERVAL_NS)
`define SFRS_HOLD_DEV_CYC `SFRS_CYC_DN(`SFRS_RESET_RECOVERY_HOLD_NS)
`define SFRS_HOLD_HOST_CYC `SFRS_CYC_UP(`SFRS_RESET_RECOVERY_HOLD_NS)
`define SFRS_RP_CYC `SFRS_CYC_UP(`SFRS_RESET_PULSE_WIDTH_NS)
`define SFRS_RH_CYC `SFRS_CYC_UP(`SFRS_RELEASE_TO_SELECT_DELAY_NS)
`define SFRS_RS_CYC `SFRS_CYC_UP(`SFRS_RESET_REARM_SETUP_NS)
`define SFRS_GAP_READ_CYC `SFRS_CYC_UP(`SFRS_DESELECT_GAP_READ_NS)
`define SFRS_GAP_PROG_CYC `SFRS_CYC_UP(`SFRS_DESELECT_GAP_PROG_NS)
`define SFRS_OP_CYC 1000
`define SFRS_CNT_W 16

// Serial clock limits in MHz per command class
`define SFRS_F_NORM_MHZ 50
`define SFRS_F_SINGLE_MHZ 133
`define SFRS_F_MULTI_MHZ 104
`define SFRS_F_QPROG_MHZ 80
// Device samples the link clock, so a half period never drops below this
`define SFRS_MIN_HALF 8
`define SFRS_HALF_RAW(f) ((`SFRS_CLK_MHZ + 2 * (f) - 1) / (2 * (f)))
`define SFRS_HALF(f) ((`SFRS_HALF_RAW(f) > `SFRS_MIN_HALF) ? `SFRS_HALF_RAW(f) : `SFRS_MIN_HALF)

`endif

// File: verilog/sfrs_pkg.sv
package sfrs_pkg;

  typedef enum logic [1:0] {
    CLS_NORMAL_READ,
    CLS_SINGLE,
    CLS_MULTI_READ,
    CLS_QUAD_PROGRAM
  } sfrs_cls_t;

  typedef enum logic [2:0] {
    DS_OFF,
    DS_POR,
    DS_RSTLOW,
    DS_READY,
    DS_PULSE,
    DS_HOLD
  } sfrs_dst_t;

  typedef enum logic [2:0] {
    HS_WAITPWR,
    HS_PU,
    HS_IDLE,
    HS_XFER,
    HS_GAP,
    HS_RLOW,
    HS_RHOLD
  } sfrs_hst_t;

endpackage

// File: verilog/sfrs_if.sv
`timescale 1ns/10ps
interface sfrs_if;
  logic sck;
  logic csN;
  logic rstPinN;
  logic si;
  logic so;
  logic soOe;
  logic misoLine;

  // Pull-up on the data-out wire while the device floats it
  assign misoLine = soOe ? so : 1'b1;

  modport dev
  (
    input  sck,
    input  csN,
    input  rstPinN,
    input  si,
    output so,
    output soOe
  );

  modport host
  (
    output sck,
    output csN,
    output rstPinN,
    output si,
    input  misoLine
  );
endinterface

// File: verilog/sfrs_dev.sv
`timescale 1ns/10ps
`include "sfrs_consts.svh"
module sfrs_dev
  import sfrs_pkg::*;
#(
  parameter int unsigned PU_CYC   = `SFRS_PU_CYC,
  parameter int unsigned HOLD_CYC = `SFRS_HOLD_DEV_CYC,
  parameter int unsigned OP_CYC   = `SFRS_OP_CYC
)
(
  // Clock and reset
  input  wire logic       clk,
  input  wire logic       rst_b,
  // Link pins
  sfrs_if.dev             lnk,
  // Supply monitor and fault strap
  input  wire logic       vccOk,
  input  wire logic       porFault,
  // User side
  input  wire logic       opStart,
  input  wire logic [7:0] txByte,
  output logic            cmdValid,
  output logic [7:0]      cmdByte,
  output logic            devReady,
  output logic            devActive,
  output logic            devStandby,
  output logic            opBusy
);

  localparam logic [`SFRS_CNT_W-1:0] PU_LOAD   = `SFRS_CNT_W'(PU_CYC - 1);
  localparam logic [`SFRS_CNT_W-1:0] HOLD_LOAD = `SFRS_CNT_W'(HOLD_CYC - 1);
  localparam logic [`SFRS_CNT_W-1:0] OP_LOAD   = `SFRS_CNT_W'(OP_CYC);
  localparam logic [5:0]             RP_LAST   = 6'(`SFRS_RP_CYC - 1);

  sfrs_dst_t               state_ff;
  sfrs_dst_t               nxt_state;
  logic [`SFRS_CNT_W-1:0]  cnt_ff;
  logic [`SFRS_CNT_W-1:0]  nxt_cnt;
  logic [5:0]              pulseCnt_ff;
  logic [5:0]              nxt_pulseCnt;
  logic                    porBad_ff;
  logic [3:0]              pinMeta_ff;
  logic [3:0]              pinSync_ff;
  logic [3:0]              pinLast_ff;
  logic [7:0]              rxSh_ff;
  logic [7:0]              txSh_ff;
  logic [2:0]              bitCnt_ff;
  logic                    so_ff;
  logic                    soOe_ff;
  logic                    cmdValid_ff;
  logic [7:0]              cmdByte_ff;
  logic [`SFRS_CNT_W-1:0]  busyCnt_ff;
  logic [`SFRS_CNT_W-1:0]  nxt_busyCnt;
  logic                    devReady_ff;
  logic                    devActive_ff;
  logic                    devStandby_ff;
  logic                    opBusy_ff;

  // Pin samples, levels read from the second stage, edges against the third
  wire        sckS     = pinSync_ff[3];
  wire        csS      = pinSync_ff[2];
  wire        rstS     = pinSync_ff[1];
  wire        siS      = pinSync_ff[0];
  wire        sckRise  = sckS & ~pinLast_ff[3];
  wire        sckFall  = ~sckS & pinLast_ff[3];
  wire        csFall   = ~csS & pinLast_ff[2];
  wire        rstFall  = ~rstS & pinLast_ff[1];
  wire        cntDone  = (cnt_ff == '0);
  wire        isReady  = (state_ff == DS_READY);
  wire        busy     = (busyCnt_ff != '0);
  wire        selected = isReady & ~csS;
  wire        byteDone = selected & sckRise & (bitCnt_ff == 3'h7);
  wire [7:0]  rxNext   = {rxSh_ff[6:0], siS};
  wire        abortOp  = (state_ff == DS_HOLD) | ~vccOk;

  always_comb
  begin
    nxt_state    = state_ff;
    nxt_cnt      = cntDone ? cnt_ff : cnt_ff - 1'b1;
    nxt_pulseCnt = '0;
    unique case (state_ff)
      DS_OFF:
      begin
        if (vccOk)
        begin
          nxt_state = DS_POR;
          nxt_cnt   = PU_LOAD;
        end
      end
      DS_POR:
      begin
        // Pin not looked at until the interval runs out
        if (cntDone)
          nxt_state = rstS ? DS_READY : DS_RSTLOW;
      end
      DS_RSTLOW:
      begin
        // Held in reset until the pin is released
        if (rstS)
          nxt_state = DS_READY;
      end
      DS_READY:
      begin
        if (rstFall && porBad_ff)
        begin
          nxt_state = DS_POR;
          nxt_cnt   = PU_LOAD;
        end
        else if (rstFall)
        begin
          nxt_state = DS_PULSE;
          nxt_cnt   = HOLD_LOAD;
        end
      end
      DS_PULSE:
      begin
        // A pulse shorter than the minimum width is a glitch
        nxt_pulseCnt = pulseCnt_ff + 1'b1;
        if (rstS)
          nxt_state = DS_READY;
        else if (pulseCnt_ff == RP_LAST)
          nxt_state = DS_HOLD;
      end
      DS_HOLD:
      begin
        if (cntDone)
          nxt_state = rstS ? DS_READY : DS_RSTLOW;
      end
      default:
      begin
        nxt_state = DS_OFF;
      end
    endcase
    if (!vccOk)
      nxt_state = DS_OFF;
  end

  // Program/erase work outlives deselection, but not the warm reset hold or a supply loss
  always_comb
  begin
    nxt_busyCnt = busy ? busyCnt_ff - 1'b1 : busyCnt_ff;
    if (abortOp)
      nxt_busyCnt = '0;
    else if (isReady && opStart && !busy)
      nxt_busyCnt = OP_LOAD;
  end

  always_ff @(posedge clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      pinMeta_ff <= 4'hf;
      pinSync_ff <= 4'hf;
      pinLast_ff <= 4'hf;
    end
    else
    begin
      pinMeta_ff <= {lnk.sck, lnk.csN, lnk.rstPinN, lnk.si};
      pinSync_ff <= pinMeta_ff;
      pinLast_ff <= pinSync_ff;
    end
  end

  always_ff @(posedge clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      state_ff    <= DS_OFF;
      cnt_ff      <= '0;
      pulseCnt_ff <= '0;
      busyCnt_ff  <= '0;
    end
    else
    begin
      state_ff    <= nxt_state;
      cnt_ff      <= nxt_cnt;
      pulseCnt_ff <= nxt_pulseCnt;
      busyCnt_ff  <= nxt_busyCnt;
    end
  end

  // Init health is caught as cold init finishes
  always_ff @(posedge clk or negedge rst_b)
  begin
    if (!rst_b)
      porBad_ff <= 1'b0;
    else if (state_ff == DS_POR && cntDone)
      porBad_ff <= porFault;
  end

  // Serial shifter, commands only taken when ready
  always_ff @(posedge clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      rxSh_ff     <= '0;
      txSh_ff     <= '0;
      bitCnt_ff   <= '0;
      so_ff       <= 1'b0;
      soOe_ff     <= 1'b0;
      cmdValid_ff <= 1'b0;
      cmdByte_ff  <= '0;
    end
    else
    begin
      cmdValid_ff <= byteDone;
      if (byteDone)
        cmdByte_ff <= rxNext;
      if (!selected)
      begin
        bitCnt_ff <= '0;
        soOe_ff   <= 1'b0;
      end
      else if (csFall)
      begin
        txSh_ff <= txByte;
        so_ff   <= txByte[7];
        soOe_ff <= 1'b1;
      end
      else if (sckRise)
      begin
        rxSh_ff   <= rxNext;
        bitCnt_ff <= bitCnt_ff + 1'b1;
      end
      else if (sckFall)
      begin
        txSh_ff <= {txSh_ff[6:0], 1'b0};
        so_ff   <= txSh_ff[6];
      end
    end
  end

  always_ff @(posedge clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      devReady_ff   <= 1'b0;
      devActive_ff  <= 1'b0;
      devStandby_ff <= 1'b0;
      opBusy_ff     <= 1'b0;
    end
    else
    begin
      devReady_ff   <= isReady;
      devActive_ff  <= selected | busy;
      devStandby_ff <= isReady & csS & ~busy;
      opBusy_ff     <= busy;
    end
  end

  assign lnk.so     = so_ff;
  assign lnk.soOe   = soOe_ff;
  assign cmdValid   = cmdValid_ff;
  assign cmdByte    = cmdByte_ff;
  assign devReady   = devReady_ff;
  assign devActive  = devActive_ff;
  assign devStandby = devStandby_ff;
  assign opBusy     = opBusy_ff;

endmodule

// File: verilog/sfrs_host.sv
`timescale 1ns/10ps
`include "sfrs_consts.svh"
module sfrs_host
  import sfrs_pkg::*;
#(
  parameter int unsigned PU_CYC   = `SFRS_PU_CYC,
  parameter int unsigned HOLD_CYC = `SFRS_HOLD_HOST_CYC
)
(
  // Clock and reset
  input  wire logic       clk,
  input  wire logic       rst_b,
  // Link pins
  sfrs_if.host            lnk,
  // User side
  input  wire logic       pwrGood,
  input  wire logic       rstReq,
  input  wire logic       cmdValid,
  input  wire sfrs_cls_t  cmdClass,
  input  wire logic [7:0] cmdByte,
  output logic            cmdReady,
  output logic            rxValid,
  output logic [7:0]      rxByte,
  output logic            linkUp
);

  localparam logic [`SFRS_CNT_W-1:0] PU_LOAD  = `SFRS_CNT_W'(PU_CYC - 1);
  // Low time plus release delay equals the whole hold
  localparam logic [`SFRS_CNT_W-1:0] LOW_LOAD = `SFRS_CNT_W'(HOLD_CYC - `SFRS_RH_CYC - 1);
  localparam logic [`SFRS_CNT_W-1:0] RH_LOAD  = `SFRS_CNT_W'(`SFRS_RH_CYC - 1);
  localparam logic [`SFRS_CNT_W-1:0] GAP_RD   = `SFRS_CNT_W'(`SFRS_GAP_READ_CYC - 1);
  localparam logic [`SFRS_CNT_W-1:0] GAP_PG   = `SFRS_CNT_W'(`SFRS_GAP_PROG_CYC - 1);
  localparam logic [3:0]             RS_MIN   = 4'(`SFRS_RS_CYC);

  sfrs_hst_t               state_ff;
  logic [`SFRS_CNT_W-1:0]  cnt_ff;
  logic [3:0]              half_ff;
  logic [3:0]              halfCnt_ff;
  logic [3:0]              highCnt_ff;
  logic                    rstPend_ff;
  logic [1:0]              misoSync_ff;
  logic [7:0]              txSh_ff;
  logic [7:0]              rxSh_ff;
  logic [2:0]              bitCnt_ff;
  logic                    sck_ff;
  logic                    csN_ff;
  logic                    rstPinN_ff;
  logic                    rxValid_ff;
  logic [7:0]              rxByte_ff;
  logic                    cmdReady_ff;
  logic                    linkUp_ff;
  logic [3:0]              classHalf;
  logic [`SFRS_CNT_W-1:0]  classGap;
  logic [`SFRS_CNT_W-1:0]  gapSel_ff;

  always_comb
  begin
    unique case (cmdClass)
      CLS_NORMAL_READ:  classHalf = 4'(`SFRS_HALF(`SFRS_F_NORM_MHZ));
      CLS_SINGLE:       classHalf = 4'(`SFRS_HALF(`SFRS_F_SINGLE_MHZ));
      CLS_MULTI_READ:   classHalf = 4'(`SFRS_HALF(`SFRS_F_MULTI_MHZ));
      CLS_QUAD_PROGRAM: classHalf = 4'(`SFRS_HALF(`SFRS_F_QPROG_MHZ));
    endcase
  end

  // Unknown single-lane commands may be program/erase, so take the long gap
  assign classGap = (cmdClass == CLS_NORMAL_READ || cmdClass == CLS_MULTI_READ)
                    ? GAP_RD : GAP_PG;

  wire cntDone  = (cnt_ff == '0);
  wire rearmOk  = (highCnt_ff >= RS_MIN);
  wire rstGo    = rstPend_ff & rearmOk;
  wire halfDone = (halfCnt_ff == '0);
  wire startCmd = (state_ff == HS_IDLE) & cmdValid & cmdReady_ff & ~rstGo;

  always_ff @(posedge clk or negedge rst_b)
  begin
    if (!rst_b)
      misoSync_ff <= 2'h3;
    else
      misoSync_ff <= {misoSync_ff[0], lnk.misoLine};
  end

  // Rearm timer: counts high time of the reset pin
  always_ff @(posedge clk or negedge rst_b)
  begin
    if (!rst_b)
      highCnt_ff <= '0;
    else if (!rstPinN_ff)
      highCnt_ff <= '0;
    else if (!rearmOk)
      highCnt_ff <= highCnt_ff + 1'b1;
  end

  // A new request wins over the clear in the same cycle
  always_ff @(posedge clk or negedge rst_b)
  begin
    if (!rst_b)
      rstPend_ff <= 1'b0;
    else if (rstReq)
      rstPend_ff <= 1'b1;
    else if (state_ff == HS_RLOW)
      rstPend_ff <= 1'b0;
  end

  always_ff @(posedge clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      state_ff   <= HS_WAITPWR;
      cnt_ff     <= '0;
      half_ff    <= '0;
      halfCnt_ff <= '0;
      gapSel_ff  <= '0;
      txSh_ff    <= '0;
      rxSh_ff    <= '0;
      bitCnt_ff  <= '0;
      sck_ff     <= 1'b0;
      csN_ff     <= 1'b1;
      rstPinN_ff <= 1'b1;
      rxValid_ff <= 1'b0;
      rxByte_ff  <= '0;
    end
    else
    begin
      rxValid_ff <= 1'b0;
      if (!cntDone)
        cnt_ff <= cnt_ff - 1'b1;
      unique case (state_ff)
        HS_WAITPWR:
        begin
          csN_ff <= 1'b1;
          if (pwrGood)
          begin
            state_ff <= HS_PU;
            cnt_ff   <= PU_LOAD;
          end
        end
        HS_PU:
        begin
          if (cntDone)
            state_ff <= HS_IDLE;
        end
        HS_IDLE:
        begin
          if (rstGo)
          begin
            state_ff   <= HS_RLOW;
            rstPinN_ff <= 1'b0;
            cnt_ff     <= LOW_LOAD;
          end
          else if (startCmd)
          begin
            state_ff   <= HS_XFER;
            csN_ff     <= 1'b0;
            txSh_ff    <= cmdByte;
            half_ff    <= classHalf;
            halfCnt_ff <= classHalf - 1'b1;
            gapSel_ff  <= classGap;
            bitCnt_ff  <= '0;
          end
        end
        HS_XFER:
        begin
          if (rstGo)
          begin
            state_ff   <= HS_RLOW;
            csN_ff     <= 1'b1;
            sck_ff     <= 1'b0;
            rstPinN_ff <= 1'b0;
            cnt_ff     <= LOW_LOAD;
          end
          else if (!halfDone)
            halfCnt_ff <= halfCnt_ff - 1'b1;
          else
          begin
            halfCnt_ff <= half_ff - 1'b1;
            sck_ff     <= ~sck_ff;
            if (!sck_ff)
              rxSh_ff <= {rxSh_ff[6:0], misoSync_ff[1]};
            else if (bitCnt_ff == 3'h7)
            begin
              state_ff   <= HS_GAP;
              csN_ff     <= 1'b1;
              cnt_ff     <= gapSel_ff;
              rxValid_ff <= 1'b1;
              rxByte_ff  <= rxSh_ff;
            end
            else
            begin
              txSh_ff   <= {txSh_ff[6:0], 1'b0};
              bitCnt_ff <= bitCnt_ff + 1'b1;
            end
          end
        end
        HS_GAP:
        begin
          if (cntDone)
            state_ff <= HS_IDLE;
        end
        HS_RLOW:
        begin
          if (cntDone)
          begin
            state_ff   <= HS_RHOLD;
            rstPinN_ff <= 1'b1;
            cnt_ff     <= RH_LOAD;
          end
        end
        HS_RHOLD:
        begin
          if (cntDone)
            state_ff <= HS_IDLE;
        end
        default:
        begin
          state_ff <= HS_WAITPWR;
        end
      endcase
      if (!pwrGood)
      begin
        state_ff <= HS_WAITPWR;
        csN_ff   <= 1'b1;
        sck_ff   <= 1'b0;
      end
    end
  end

  always_ff @(posedge clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      cmdReady_ff <= 1'b0;
      linkUp_ff   <= 1'b0;
    end
    else
    begin
      cmdReady_ff <= (state_ff == HS_IDLE) & ~startCmd & ~rstGo & pwrGood;
      linkUp_ff   <= (state_ff != HS_WAITPWR) & (state_ff != HS_PU);
    end
  end

  assign lnk.sck     = sck_ff;
  assign lnk.csN     = csN_ff;
  assign lnk.rstPinN = rstPinN_ff;
  assign lnk.si      = txSh_ff[7];
  assign cmdReady    = cmdReady_ff;
  assign rxValid     = rxValid_ff;
  assign rxByte      = rxByte_ff;
  assign linkUp      = linkUp_ff;

endmodule

// File: tb/sfrs_link_properties.sv
`timescale 1ns/10ps
module sfrs_link_properties
#(
  parameter int unsigned PU_CYC   = 200,
  parameter int unsigned HOLD_CYC = 100
)
(
  // Clock and reset
  input wire logic clk,
  input wire logic rst_b,
  // Link wires
  input wire logic sck,
  input wire logic csN,
  input wire logic rstPinN,
  input wire logic si,
  input wire logic so,
  input wire logic soOe,
  input wire logic misoLine
);
  localparam int RP_CYC = 40;
  localparam int RH_CYC = 10;
  localparam int RS_CYC = 10;

  // Saturating, so a long idle stretch never wraps into a false pass
  logic [15:0] upCnt_ff;
  logic [15:0] lowCnt_ff;
  logic [15:0] highCnt_ff;
  logic [15:0] fallCnt_ff;
  wire         pinFall     = !rstPinN && (lowCnt_ff == 16'h0);
  wire  [15:0] nxt_upCnt   = (&upCnt_ff) ? upCnt_ff : upCnt_ff + 16'h1;
  wire  [15:0] nxt_lowCnt  = rstPinN ? 16'h0 : ((&lowCnt_ff) ? lowCnt_ff : lowCnt_ff + 16'h1);
  wire  [15:0] nxt_highCnt = !rstPinN ? 16'h0 : ((&highCnt_ff) ? highCnt_ff : highCnt_ff + 16'h1);
  wire  [15:0] nxt_fallCnt = pinFall ? 16'h0 : ((&fallCnt_ff) ? fallCnt_ff : fallCnt_ff + 16'h1);

  always_ff @(posedge clk or negedge rst_b)
    if (!rst_b)
    begin
      upCnt_ff   <= 16'h0;
      lowCnt_ff  <= 16'h0;
      highCnt_ff <= 16'h0;
      fallCnt_ff <= 16'hffff;
    end
    else
    begin
      upCnt_ff   <= nxt_upCnt;
      lowCnt_ff  <= nxt_lowCnt;
      highCnt_ff <= nxt_highCnt;
      fallCnt_ff <= nxt_fallCnt;
    end

  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_b);

  sequence s_sckRise;
    $rose(sck);
  endsequence
  sequence s_sckFallSel;
    $fell(sck) && !csN;
  endsequence
  sequence s_deselHeld;
    csN [*5];
  endsequence

  property p_pu;     !csN |-> upCnt_ff >= PU_CYC; endproperty
  property p_hold;   !csN |-> fallCnt_ff >= HOLD_CYC; endproperty
  property p_rh;     !csN |-> highCnt_ff >= RH_CYC; endproperty
  property p_rs;     pinFall |-> highCnt_ff >= RS_CYC; endproperty
  property p_pulse;
    rstPinN && (lowCnt_ff != 16'h0) |-> lowCnt_ff >= RP_CYC && lowCnt_ff + RH_CYC >= HOLD_CYC;
  endproperty
  property p_float;  lowCnt_ff >= 50 |-> !soOe; endproperty
  property p_selRst; !rstPinN |-> csN; endproperty
  property p_gap;    $rose(csN) |-> csN [*2]; endproperty
  property p_halfHi; s_sckRise |-> sck [*8]; endproperty
  property p_halfLo; s_sckFallSel |-> !sck [*8]; endproperty
  property p_desel;  s_deselHeld |-> !soOe; endproperty

  a_pu: assert property (p_pu) else $error("select during power-up");
  a_hold: assert property (p_hold) else $error("select inside recovery hold");
  a_rh: assert property (p_rh) else $error("select too soon after reset release");
  a_rs: assert property (p_rs) else $error("reset re-armed too soon");
  a_pulse: assert property (p_pulse) else $error("reset pulse too short");
  a_float: assert property (p_float) else $error("output driven during reset");
  a_selRst: assert property (p_selRst) else $error("select while reset low");
  a_gap: assert property (p_gap) else $error("deselect gap too short");
  a_halfHi: assert property (p_halfHi) else $error("link clock high too short");
  a_halfLo: assert property (p_halfLo) else $error("link clock low too short");
  a_desel: assert property (p_desel) else $error("output driven while deselected");
endmodule

// File: tb/testbench.sv
`timescale 1ns/10ps
module testbench
  import sfrs_pkg::*;
;
  localparam int PU   = 200;
  localparam int HOLD = 100;
  logic       clk, rst_b, vccOk, porFault, porFault2, opStart, pwrGood, rstReq, hValid, rst2N;
  logic       dCmdValid, devReady, devActive, devStandby, opBusy, cmdReady, rxValid, linkUp;
  logic       devReady2, prevSck;
  logic [7:0] txByte, hByte, dCmdByte, rxByte, wireBits, gotByte;
  sfrs_cls_t  hClass;
  int         error_cnt, n_checks;

  sfrs_if lnk();
  sfrs_if lnk2();
  // Second device has no host: its pins are ours to misuse
  assign lnk2.sck     = 1'b0;
  assign lnk2.csN     = 1'b1;
  assign lnk2.si      = 1'b0;
  assign lnk2.rstPinN = rst2N;

  sfrs_dev #(.PU_CYC(PU), .HOLD_CYC(HOLD)) i_sfrs_dev (.clk(clk), .rst_b(rst_b), .lnk(lnk),
    .vccOk(vccOk), .porFault(porFault), .opStart(opStart), .txByte(txByte),
    .cmdValid(dCmdValid), .cmdByte(dCmdByte), .devReady(devReady), .devActive(devActive),
    .devStandby(devStandby), .opBusy(opBusy));
  sfrs_dev #(.PU_CYC(PU), .HOLD_CYC(HOLD)) i_sfrs_dev2 (.clk(clk), .rst_b(rst_b), .lnk(lnk2),
    .vccOk(vccOk), .porFault(porFault2), .opStart(1'b0), .txByte(8'h00), .cmdValid(),
    .cmdByte(), .devReady(devReady2), .devActive(), .devStandby(), .opBusy());
  sfrs_host #(.PU_CYC(PU), .HOLD_CYC(HOLD)) i_sfrs_host (.clk(clk), .rst_b(rst_b), .lnk(lnk),
    .pwrGood(pwrGood), .rstReq(rstReq), .cmdValid(hValid), .cmdClass(hClass), .cmdByte(hByte),
    .cmdReady(cmdReady), .rxValid(rxValid), .rxByte(rxByte), .linkUp(linkUp));
  sfrs_link_properties #(.PU_CYC(PU), .HOLD_CYC(HOLD)) i_sfrs_link_properties (.clk(clk),
    .rst_b(rst_b), .sck(lnk.sck), .csN(lnk.csN), .rstPinN(lnk.rstPinN), .si(lnk.si),
    .so(lnk.so), .soOe(lnk.soOe), .misoLine(lnk.misoLine));

  // Wire monitor: bits taken at each link clock rise, first bit ends up on top
  always @(posedge clk)
  begin
    prevSck <= lnk.sck;
    if (lnk.sck && !prevSck && !lnk.csN) wireBits <= {wireBits[6:0], lnk.si};
    if (dCmdValid) gotByte <= dCmdByte;
  end

  initial
  begin
    clk = 1'b0;
    forever #2.5 clk = ~clk;
  end

  task end_sim;
    $display("checks %0d mismatches %0d", n_checks, error_cnt);
    if (error_cnt == 0 && n_checks > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask

  task chk(input logic [7:0] seen, input logic [7:0] exp, input string what);
    n_checks++;
    if (seen !== exp)
    begin
      error_cnt++;
      $display("BAD %0t %s", $time, what);
    end
  endtask

  task wait_sig(input int sel, input int lim, output int n);
    for (n = 0; n < lim; n++)
    begin
      @(posedge clk);
      #1;
      if (sel == 0 ? devReady === 1'b1 : sel == 1 ? cmdReady === 1'b1 :
          sel == 2 ? rxValid === 1'b1 : sel == 3 ? devReady2 === 1'b1 : lnk.rstPinN === 1'b0)
        return;
    end
    error_cnt++;
    $display("BAD %0t wait ran out", $time);
    end_sim();
  endtask

  task t_powerup;
    int n;
    repeat (100) @(posedge clk);
    rst2N <= 1'b1;
    wait_sig(0, PU, n);
    chk(8'(n + 100 >= PU - 1 && n + 100 <= PU + 10), 8'h01, "ready time");
    chk(devStandby, 8'h01, "standby after init");
    chk(lnk.misoLine, 8'h01, "data line floats");
    @(posedge clk);
    #1;
    chk(devReady2, 8'h01, "reset pin not ignored");
    wait_sig(1, 50, n);
    chk(linkUp, 8'h01, "link up");
    $display("test power-up done");
  endtask

  task t_xfer(input sfrs_cls_t c, input logic [7:0] b);
    int n;
    int gap;
    wait_sig(1, 100, n);
    @(posedge clk);
    hValid <= 1'b1;
    hClass <= c;
    hByte  <= b;
    txByte <= ~b;
    @(posedge clk);
    hValid <= 1'b0;
    wait_sig(2, 400, n);
    chk(8'(n >= 125), 8'h01, "frame faster than clock limit");
    chk(gotByte, b, "device byte");
    chk(wireBits, b, "wire bit order");
    chk(rxByte, ~b, "host byte");
    // Deselect gap in clk cycles: 10 ns for reads, 50 ns for anything that may program
    gap = (c == CLS_NORMAL_READ || c == CLS_MULTI_READ) ? 2 : 10;
    wait_sig(1, 100, n);
    chk(8'(n >= gap), 8'h01, "deselect gap too short");
    $display("test transfer class %0d done", c);
  endtask

  task t_op_reset;
    int n;
    @(posedge clk) opStart <= 1'b1;
    @(posedge clk) opStart <= 1'b0;
    repeat (2) @(posedge clk);
    #1;
    chk({opBusy, devActive, devStandby}, 8'h06, "op busy flags");
    @(posedge clk) rstReq <= 1'b1;
    @(posedge clk) rstReq <= 1'b0;
    wait_sig(4, 50, n);
    repeat (60) @(posedge clk);
    #1;
    chk({opBusy, lnk.soOe, devReady, cmdReady}, 8'h00, "abort and lockout");
    chk(lnk.misoLine, 8'h01, "outputs float");
    wait_sig(0, HOLD, n);
    chk(8'(n + 60 <= HOLD + 12), 8'h01, "warm reset too long");
    @(posedge clk);
    #1;
    chk(devStandby, 8'h01, "back to standby");
    $display("test op reset done");
  endtask

  task t_dev2;
    int n;
    // Failed cold init first: any fall reruns the whole init, then init is healthy
    @(posedge clk);
    rst2N     <= 1'b0;
    porFault2 <= 1'b0;
    repeat (50) @(posedge clk);
    rst2N <= 1'b1;
    repeat (HOLD - 20) @(posedge clk);
    #1;
    chk(devReady2, 8'h00, "warm reset after failed init");
    wait_sig(3, PU, n);
    chk(8'(n + HOLD + 30 >= PU - 5), 8'h01, "full init not rerun");
    // Healthy now, so a pulse below the minimum width is a glitch
    @(posedge clk) rst2N <= 1'b0;
    repeat (20) @(posedge clk);
    rst2N <= 1'b1;
    repeat (40) @(posedge clk);
    #1;
    chk(devReady2, 8'h01, "short pulse acted on");
    $display("test failed init done");
  endtask

  initial
  begin
    rst_b     = 1'b0;
    vccOk     = 1'b1;
    pwrGood   = 1'b1;
    porFault  = 1'b0;
    porFault2 = 1'b1;
    opStart   = 1'b0;
    txByte    = 8'h00;
    rstReq    = 1'b0;
    hValid    = 1'b0;
    hClass    = CLS_NORMAL_READ;
    hByte     = 8'h00;
    rst2N     = 1'b0;
    error_cnt = 0;
    n_checks  = 0;
    repeat (6) @(posedge clk);
    rst_b <= 1'b1;
    t_powerup();
    for (int c = 0; c < 4; c++) t_xfer(sfrs_cls_t'(c), 8'h96 + 8'(c));
    t_op_reset();
    t_xfer(CLS_QUAD_PROGRAM, 8'h01);
    t_dev2();
    end_sim();
  end
endmodule
